// File: hdl/console_pkg.sv
// Constants, field layout and types of the console examine/deposit unit.
// Assumes a 32-bit APB register bus with 8-bit byte addresses.
package console_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CMD         = 8'h00;
  localparam logic [7:0] OFF_DEFAULTS    = 8'h04;
  localparam logic [7:0] OFF_STATUS      = 8'h08;
  localparam logic [7:0] OFF_DEF_ADDR    = 8'h0c;
  localparam logic [7:0] OFF_LAST_ADDR   = 8'h10;
  localparam logic [7:0] OFF_ADDR_DIGITS = 8'h14;
  localparam logic [7:0] OFF_ADDR_CTRL   = 8'h18;
  localparam logic [7:0] OFF_DATA_DIGITS = 8'h1c;
  localparam logic [7:0] OFF_DATA_CTRL   = 8'h20;
  localparam logic [7:0] OFF_RES_ADDR    = 8'h24;
  localparam logic [7:0] OFF_RES_LO      = 8'h28;
  localparam logic [7:0] OFF_RES_HI      = 8'h2c;
  localparam logic [7:0] OFF_RES_TAG     = 8'h30;

  // Address spaces, data lengths, address modes and register names
  typedef enum logic [2:0] {
    SPACE_VIRTUAL, SPACE_PHYSICAL, SPACE_INTERNAL_BUS, SPACE_VIDEO_BUS, SPACE_GENERAL, SPACE_INTERNAL_REG
  } space_t;
  typedef enum logic [1:0] {LEN_BYTE, LEN_WORD, LEN_LONG, LEN_QUAD} len_t;
  typedef enum logic [1:0] {AMODE_EXPLICIT, AMODE_NONE, AMODE_PLUS, AMODE_STAR} amode_t;
  typedef enum logic [1:0] {NAME_NONE, NAME_PROGRAM_COUNTER, NAME_STACK_POINTER} name_t;

  // Command register fields
  localparam int CMD_DEPOSIT   = 0;
  localparam int CMD_HAS_SPACE = 1;
  localparam int CMD_SPACE_LSB = 2;
  localparam int CMD_HAS_LEN   = 5;
  localparam int CMD_LEN_LSB   = 6;
  localparam int CMD_AMODE_LSB = 8;
  localparam int CMD_NAME_LSB  = 10;
  localparam int CMD_REPEAT    = 12;
  localparam int CMD_COUNT_LSB = 16;
  localparam int CMD_ABORT     = 31;

  // Defaults register fields and reset values
  localparam int DEF_SPACE_LSB = 0;
  localparam int DEF_LEN_LSB   = 3;
  localparam int DEF_OCTAL     = 5;
  localparam logic [2:0] DEF_SPACE_RST = 3'h1;
  localparam logic [1:0] DEF_LEN_RST   = 2'h2;
  localparam logic       DEF_OCTAL_RST = 1'b0;

  // Status register fields
  localparam int ST_BUSY       = 0;
  localparam int ST_ERR        = 1;
  localparam int ST_SPACE_LSB  = 4;
  localparam int ST_REMAIN_LSB = 8;

  // Argument control fields: leftmost char, second char, digit count
  localparam int CT_FIRST_LSB  = 8;
  localparam int CT_SECOND_LSB = 0;
  localparam int CT_NDIG_LSB   = 16;

  // Register indices and display tags
  localparam logic [31:0] PROGRAM_COUNTER_IDX = 32'h0000000f;
  localparam logic [31:0] STACK_POINTER_IDX   = 32'h0000000e;
  localparam logic [3:0]  GPR_LAST            = 4'hf;
  localparam logic [7:0]  TAG_PHYS            = 8'h50;
  localparam logic [7:0]  TAG_GEN             = 8'h47;

  // Radix prefix characters
  localparam logic [7:0] CH_PERCENT = 8'h25;
  localparam logic [7:0] CH_O_UP    = 8'h4f;
  localparam logic [7:0] CH_O_LO    = 8'h6f;
  localparam logic [7:0] CH_X_UP    = 8'h58;
  localparam logic [7:0] CH_X_LO    = 8'h78;

endpackage

// File: hdl/numeric_arg_decoder.sv
// Turns an entered digit string with optional radix prefix into a value.
// Assumes digits are right aligned, one nibble each, least significant first.
`timescale 1ns/1ns
`default_nettype none
module numeric_arg_decoder #(
  parameter int DIGITS = 8
) (
  // Argument text
  input  wire logic [4*DIGITS-1:0] digits,
  input  wire logic [3:0]          ndigits,
  input  wire logic [7:0]          first_char,
  input  wire logic [7:0]          second_char,
  // Default radix
  input  wire logic                def_octal,
  // Result
  output logic      [31:0]         value,
  output logic                     octal
);

  logic            pct;
  logic [31:0]     term [DIGITS];

  assign pct   = (first_char == console_pkg::CH_PERCENT);
  // Prefix only counts as the two leftmost characters
  assign octal = (pct && (second_char == console_pkg::CH_O_UP || second_char == console_pkg::CH_O_LO)) ? 1'b1 :
                 (pct && (second_char == console_pkg::CH_X_UP || second_char == console_pkg::CH_X_LO)) ? 1'b0 :
                 def_octal;

  for (genvar i = 0; i < DIGITS; i++) begin : g_digit
    assign term[i] = (4'(i) >= ndigits) ? 32'h0 :
                     octal ? ({29'h0, digits[4*i +: 3]} << (3*i)) : ({28'h0, digits[4*i +: 4]} << (4*i));
  end

  always_comb begin
    value = 32'h0;
    for (int k = 0; k < DIGITS; k++) begin
      value = value | term[k];
    end
  end

endmodule
`default_nettype wire

// File: hdl/console_addr_unit.sv
// Console examine/deposit address and length resolution with repeat stepping.
// Assumes an APB master for commands and a memory port that acknowledges each request.
`timescale 1ns/1ns
`default_nettype none
module console_addr_unit #(
  parameter int COUNT_W = 8
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Memory and register space port
  output logic             mem_req,
  output logic             mem_we,
  output logic      [2:0]  mem_space,
  output logic      [1:0]  mem_len,
  output logic      [31:0] mem_addr,
  output logic      [63:0] mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic        mem_err,
  input  wire logic [63:0] mem_rdata,
  // Display and error events
  output logic             disp_valid,
  output logic      [7:0]  disp_tag,
  output logic      [31:0] disp_addr,
  output logic      [63:0] disp_data,
  output logic             err_valid
);

  typedef enum logic {S_IDLE, S_ISSUE} state_t;

  state_t               state_r, state_nxt;
  logic [2:0]           def_space_r, def_space_nxt;
  logic [1:0]           def_len_r, def_len_nxt;
  logic                 def_octal_r, def_octal_nxt;
  logic [31:0]          def_addr_r, def_addr_nxt;
  logic [31:0]          last_addr_r, last_addr_nxt;
  logic [2:0]           last_space_r, last_space_nxt;
  logic                 err_r, err_nxt;
  logic [COUNT_W-1:0]   remain_r, remain_nxt;
  logic [31:0]          adig_r, adig_nxt;
  logic [19:0]          actl_r, actl_nxt;
  logic [31:0]          ddig_r, ddig_nxt;
  logic [19:0]          dctl_r, dctl_nxt;
  logic                 we_r, we_nxt;
  logic [2:0]           cur_space_r, cur_space_nxt;
  logic [1:0]           cur_len_r, cur_len_nxt;
  logic [31:0]          cur_addr_r, cur_addr_nxt;
  logic [63:0]          cur_data_r, cur_data_nxt;
  logic                 disp_valid_r, disp_valid_nxt;
  logic [7:0]           disp_tag_r, disp_tag_nxt;
  logic [31:0]          disp_addr_r, disp_addr_nxt;
  logic [63:0]          disp_data_r, disp_data_nxt;
  logic                 err_valid_r, err_valid_nxt;
  logic [31:0]          prdata_r, prdata_nxt;
  logic                 hit;
  logic                 wr, start, abort_wr, ack_ok;
  logic [31:0]          aval, dval;
  logic [2:0]           sel_space;
  logic [1:0]           sel_len;
  logic [31:0]          sel_addr;
  logic [31:0]          step;
  logic [1:0]           amode;
  logic [1:0]           name;

  function automatic logic [31:0] step_addr(input logic [2:0] sp, input logic [1:0] ln, input logic [31:0] a);
    if (sp == console_pkg::SPACE_GENERAL) begin
      step_addr = (a[3:0] == console_pkg::GPR_LAST) ? 32'h0 : a + 32'h1;
    end else if (sp == console_pkg::SPACE_INTERNAL_REG) begin
      step_addr = a + 32'h1;
    end else begin
      step_addr = a + (32'h1 << ln);
    end
  endfunction

  function automatic logic [63:0] len_mask(input logic [1:0] ln);
    case (ln)
      console_pkg::LEN_BYTE: len_mask = 64'h00000000000000ff;
      console_pkg::LEN_WORD: len_mask = 64'h000000000000ffff;
      console_pkg::LEN_LONG: len_mask = 64'h00000000ffffffff;
      default:               len_mask = 64'hffffffffffffffff;
    endcase
  endfunction

  numeric_arg_decoder #(.DIGITS(8)) u_addr_arg (
    .digits      (adig_r),
    .ndigits     (actl_r[console_pkg::CT_NDIG_LSB +: 4]),
    .first_char  (actl_r[console_pkg::CT_FIRST_LSB +: 8]),
    .second_char (actl_r[console_pkg::CT_SECOND_LSB +: 8]),
    .def_octal   (def_octal_r),
    .value       (aval),
    .octal       ()
  );

  numeric_arg_decoder #(.DIGITS(8)) u_data_arg (
    .digits      (ddig_r),
    .ndigits     (dctl_r[console_pkg::CT_NDIG_LSB +: 4]),
    .first_char  (dctl_r[console_pkg::CT_FIRST_LSB +: 8]),
    .second_char (dctl_r[console_pkg::CT_SECOND_LSB +: 8]),
    .def_octal   (def_octal_r),
    .value       (dval),
    .octal       ()
  );

  assign wr       = psel && penable && pwrite;
  assign abort_wr = wr && (paddr == console_pkg::OFF_CMD) && pwdata[console_pkg::CMD_ABORT];
  assign start    = wr && (paddr == console_pkg::OFF_CMD) && !pwdata[console_pkg::CMD_ABORT] && (state_r == S_IDLE);
  assign ack_ok   = mem_req && mem_ack && !mem_err;
  assign amode    = pwdata[console_pkg::CMD_AMODE_LSB +: 2];
  assign name     = pwdata[console_pkg::CMD_NAME_LSB +: 2];
  assign step     = step_addr(cur_space_r, cur_len_r, cur_addr_r);

  // Resolve space, length and address of a new command
  always_comb begin
    if (name != console_pkg::NAME_NONE) begin
      sel_space = console_pkg::SPACE_GENERAL;
    end else if (pwdata[console_pkg::CMD_HAS_SPACE]) begin
      sel_space = pwdata[console_pkg::CMD_SPACE_LSB +: 3];
    end else if (amode != console_pkg::AMODE_EXPLICIT) begin
      sel_space = last_space_r;
    end else begin
      sel_space = def_space_r;
    end
    if (sel_space == console_pkg::SPACE_GENERAL || sel_space == console_pkg::SPACE_INTERNAL_REG) begin
      sel_len = console_pkg::LEN_LONG;
    end else if (pwdata[console_pkg::CMD_HAS_LEN]) begin
      sel_len = pwdata[console_pkg::CMD_LEN_LSB +: 2];
    end else begin
      sel_len = def_len_r;
    end
    if (name == console_pkg::NAME_PROGRAM_COUNTER) begin
      sel_addr = console_pkg::PROGRAM_COUNTER_IDX;
    end else if (name == console_pkg::NAME_STACK_POINTER) begin
      sel_addr = console_pkg::STACK_POINTER_IDX;
    end else if (amode == console_pkg::AMODE_EXPLICIT) begin
      sel_addr = aval;
    end else if (amode == console_pkg::AMODE_STAR) begin
      sel_addr = last_addr_r;
    end else begin
      sel_addr = def_addr_r;
    end
  end

  // Register read mux and decode
  always_comb begin
    hit        = 1'b1;
    prdata_nxt = prdata_r;
    if (paddr == console_pkg::OFF_CMD) begin
      prdata_nxt = 32'h0;
    end else if (paddr == console_pkg::OFF_DEFAULTS) begin
      prdata_nxt = {26'h0, def_octal_r, def_len_r, def_space_r};
    end else if (paddr == console_pkg::OFF_STATUS) begin
      prdata_nxt = {16'h0, remain_r, 1'b0, last_space_r, 2'h0, err_r, state_r == S_ISSUE};
    end else if (paddr == console_pkg::OFF_DEF_ADDR) begin
      prdata_nxt = def_addr_r;
    end else if (paddr == console_pkg::OFF_LAST_ADDR) begin
      prdata_nxt = last_addr_r;
    end else if (paddr == console_pkg::OFF_ADDR_DIGITS) begin
      prdata_nxt = adig_r;
    end else if (paddr == console_pkg::OFF_ADDR_CTRL) begin
      prdata_nxt = {12'h0, actl_r};
    end else if (paddr == console_pkg::OFF_DATA_DIGITS) begin
      prdata_nxt = ddig_r;
    end else if (paddr == console_pkg::OFF_DATA_CTRL) begin
      prdata_nxt = {12'h0, dctl_r};
    end else if (paddr == console_pkg::OFF_RES_ADDR) begin
      prdata_nxt = disp_addr_r;
    end else if (paddr == console_pkg::OFF_RES_LO) begin
      prdata_nxt = disp_data_r[31:0];
    end else if (paddr == console_pkg::OFF_RES_HI) begin
      prdata_nxt = disp_data_r[63:32];
    end else if (paddr == console_pkg::OFF_RES_TAG) begin
      prdata_nxt = {24'h0, disp_tag_r};
    end else begin
      hit        = 1'b0;
      prdata_nxt = 32'h0;
    end
    if (!(psel && !penable && !pwrite)) begin
      prdata_nxt = prdata_r;
    end
  end

  // Next state of the command engine and registers
  always_comb begin
    state_nxt      = state_r;
    def_space_nxt  = def_space_r;
    def_len_nxt    = def_len_r;
    def_octal_nxt  = def_octal_r;
    def_addr_nxt   = def_addr_r;
    last_addr_nxt  = last_addr_r;
    last_space_nxt = last_space_r;
    err_nxt        = err_r;
    remain_nxt     = remain_r;
    adig_nxt       = adig_r;
    actl_nxt       = actl_r;
    ddig_nxt       = ddig_r;
    dctl_nxt       = dctl_r;
    we_nxt         = we_r;
    cur_space_nxt  = cur_space_r;
    cur_len_nxt    = cur_len_r;
    cur_addr_nxt   = cur_addr_r;
    cur_data_nxt   = cur_data_r;
    disp_valid_nxt = 1'b0;
    disp_tag_nxt   = disp_tag_r;
    disp_addr_nxt  = disp_addr_r;
    disp_data_nxt  = disp_data_r;
    err_valid_nxt  = 1'b0;
    if (wr) begin
      if (paddr == console_pkg::OFF_DEFAULTS) begin
        def_space_nxt = pwdata[console_pkg::DEF_SPACE_LSB +: 3];
        def_len_nxt   = pwdata[console_pkg::DEF_LEN_LSB +: 2];
        def_octal_nxt = pwdata[console_pkg::DEF_OCTAL];
      end else if (paddr == console_pkg::OFF_STATUS && pwdata[console_pkg::ST_ERR]) begin
        err_nxt = 1'b0;
      end else if (paddr == console_pkg::OFF_ADDR_DIGITS) begin
        adig_nxt = pwdata;
      end else if (paddr == console_pkg::OFF_ADDR_CTRL) begin
        actl_nxt = pwdata[19:0];
      end else if (paddr == console_pkg::OFF_DATA_DIGITS) begin
        ddig_nxt = pwdata;
      end else if (paddr == console_pkg::OFF_DATA_CTRL) begin
        dctl_nxt = pwdata[19:0];
      end
    end
    case (state_r)
      S_IDLE: begin
        if (start) begin
          state_nxt     = S_ISSUE;
          we_nxt        = pwdata[console_pkg::CMD_DEPOSIT];
          cur_space_nxt = sel_space;
          cur_len_nxt   = sel_len;
          cur_addr_nxt  = sel_addr;
          cur_data_nxt  = {32'h0, dval} & len_mask(sel_len);
          if (!pwdata[console_pkg::CMD_REPEAT]) begin
            remain_nxt = '0;
          end else if (pwdata[console_pkg::CMD_COUNT_LSB +: COUNT_W] == '0) begin
            remain_nxt = COUNT_W'(1);
          end else begin
            remain_nxt = pwdata[console_pkg::CMD_COUNT_LSB +: COUNT_W];
          end
        end
      end
      default: begin
        if (mem_ack && mem_err) begin
          state_nxt     = S_IDLE;
          remain_nxt    = '0;
          err_valid_nxt = 1'b1;
        end else if (mem_ack) begin
          last_addr_nxt  = cur_addr_r;
          last_space_nxt = cur_space_r;
          def_addr_nxt   = step;
          disp_valid_nxt = 1'b1;
          disp_addr_nxt  = cur_addr_r;
          disp_data_nxt  = (we_r ? cur_data_r : mem_rdata) & len_mask(cur_len_r);
          disp_tag_nxt   = (cur_space_r == console_pkg::SPACE_GENERAL ||
                            cur_space_r == console_pkg::SPACE_INTERNAL_REG) ? console_pkg::TAG_GEN : console_pkg::TAG_PHYS;
          if (remain_r != '0 && !abort_wr) begin
            remain_nxt   = remain_r - COUNT_W'(1);
            cur_addr_nxt = step;
          end else begin
            state_nxt  = S_IDLE;
            remain_nxt = '0;
          end
        end
      end
    endcase
    if (abort_wr) begin
      remain_nxt = '0;
    end
    if (mem_req && mem_ack && mem_err) begin
      err_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r      <= S_IDLE;
      def_space_r  <= console_pkg::DEF_SPACE_RST;
      def_len_r    <= console_pkg::DEF_LEN_RST;
      def_octal_r  <= console_pkg::DEF_OCTAL_RST;
      def_addr_r   <= 32'h0;
      last_addr_r  <= 32'h0;
      last_space_r <= console_pkg::DEF_SPACE_RST;
      err_r        <= 1'b0;
      remain_r     <= '0;
      adig_r       <= 32'h0;
      actl_r       <= 20'h0;
      ddig_r       <= 32'h0;
      dctl_r       <= 20'h0;
      we_r         <= 1'b0;
      cur_space_r  <= console_pkg::DEF_SPACE_RST;
      cur_len_r    <= console_pkg::DEF_LEN_RST;
      cur_addr_r   <= 32'h0;
      cur_data_r   <= 64'h0;
      disp_valid_r <= 1'b0;
      disp_tag_r   <= 8'h0;
      disp_addr_r  <= 32'h0;
      disp_data_r  <= 64'h0;
      err_valid_r  <= 1'b0;
      prdata_r     <= 32'h0;
    end else begin
      state_r      <= state_nxt;
      def_space_r  <= def_space_nxt;
      def_len_r    <= def_len_nxt;
      def_octal_r  <= def_octal_nxt;
      def_addr_r   <= def_addr_nxt;
      last_addr_r  <= last_addr_nxt;
      last_space_r <= last_space_nxt;
      err_r        <= err_nxt;
      remain_r     <= remain_nxt;
      adig_r       <= adig_nxt;
      actl_r       <= actl_nxt;
      ddig_r       <= ddig_nxt;
      dctl_r       <= dctl_nxt;
      we_r         <= we_nxt;
      cur_space_r  <= cur_space_nxt;
      cur_len_r    <= cur_len_nxt;
      cur_addr_r   <= cur_addr_nxt;
      cur_data_r   <= cur_data_nxt;
      disp_valid_r <= disp_valid_nxt;
      disp_tag_r   <= disp_tag_nxt;
      disp_addr_r  <= disp_addr_nxt;
      disp_data_r  <= disp_data_nxt;
      err_valid_r  <= err_valid_nxt;
      prdata_r     <= prdata_nxt;
    end
  end

  assign prdata     = prdata_r;
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !hit;
  assign mem_req    = (state_r == S_ISSUE);
  assign mem_we     = we_r;
  assign mem_space  = cur_space_r;
  assign mem_len    = cur_len_r;
  assign mem_addr   = cur_addr_r;
  assign mem_wdata  = cur_data_r;
  assign disp_valid = disp_valid_r;
  assign disp_tag   = disp_tag_r;
  assign disp_addr  = disp_addr_r;
  assign disp_data  = disp_data_r;
  assign err_valid  = err_valid_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_err_aborts: assert property (mem_req && mem_ack && mem_err |=> !mem_req && remain_r == '0 && err_valid && err_r)
    else $error("error did not abort command");
  a_reg_long: assert property (mem_req && (mem_space == console_pkg::SPACE_GENERAL) |-> mem_len == console_pkg::LEN_LONG)
    else $error("register access not longword");
  a_default_step: assert property (ack_ok && mem_space < 3'h4 |=> def_addr_r == $past(mem_addr) + (32'h1 << $past(mem_len)))
    else $error("default address not advanced by size");
  a_gpr_wrap: assert property (ack_ok && mem_space == console_pkg::SPACE_GENERAL && mem_addr == 32'hf |=> def_addr_r == 32'h0)
    else $error("general register index did not wrap");
  a_last_addr: assert property (ack_ok |=> last_addr_r == $past(mem_addr) && last_space_r == $past(mem_space))
    else $error("last address not recorded");
  a_repeat_next: assert property (ack_ok && remain_r != '0 && !abort_wr |=> mem_req && mem_addr == def_addr_r)
    else $error("repeat did not use default address");
  a_abort_stops: assert property (abort_wr |=> remain_r == '0)
    else $error("abort left repeats pending");
  a_disp_result: assert property (ack_ok |=> disp_valid && disp_addr == $past(mem_addr) ##1 !disp_valid)
    else $error("display result missing or stretched");
  a_star_addr: assert property (start && amode == console_pkg::AMODE_STAR && name == 2'h0 |=> mem_addr == $past(last_addr_r))
    else $error("asterisk did not use last address");
  a_count_one: assert property (start && pwdata[console_pkg::CMD_REPEAT] && pwdata[23:16] == 8'h0 |=> remain_r == COUNT_W'(1))
    else $error("repeat without count not one");

endmodule
`default_nettype wire

// File: tb/mem_model.sv
// Memory and register space responder for the console unit bench.
// Assumes each request is held until acknowledged; waits vary with address.
`timescale 1ns/1ns
`default_nettype none
module mem_model #(
  parameter logic [31:0] BAD = 32'h0000dead
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Request
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  // Answer
  output logic             mem_ack,
  output logic             mem_err,
  output logic      [63:0] mem_rdata
);
  logic [1:0] wait_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack   <= 1'b0;
      mem_err   <= 1'b0;
      mem_rdata <= '0;
      wait_r    <= 2'h0;
    end else if (mem_ack) begin
      mem_ack   <= 1'b0;
      mem_err   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_r    <= mem_addr[1:0];
    end else if (mem_req && wait_r == 2'h0) begin
      mem_ack   <= 1'b1;
      mem_err   <= (mem_addr == BAD);
      mem_rdata <= {~mem_addr, mem_addr};
    end else begin
      mem_rdata <= ~mem_rdata;
      if (mem_req) wait_r <= wait_r - 2'h1;
    end
  end
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the console address unit.
// Assumes the memory responder model and APB zero-wait slave timing.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slv;
  logic [7:0] paddr = '0, disp_tag;
  logic [31:0] pwdata = '0, prdata, mem_addr, disp_addr, q, a;
  logic pready, pslverr, mem_req, mem_we, mem_ack, mem_err, disp_valid, err_valid;
  logic [2:0] mem_space;
  logic [1:0] mem_len;
  logic [63:0] mem_wdata, mem_rdata, disp_data;
  logic [103:0] seen_q[$];
  int fails = 0, checked = 0, errs = 0, seed = 32'h9088852f;
  logic [31:0] def_a = '0;
  logic [69:0] req_q[$];
  logic [2:0] sp = 3'h1;
  logic dep = 0;
  always #20 pclk = ~pclk;
  console_addr_unit DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .mem_req, .mem_we, .mem_space, .mem_len, .mem_addr, .mem_wdata, .mem_ack, .mem_err,
    .mem_rdata, .disp_valid, .disp_tag, .disp_addr, .disp_data, .err_valid);
  mem_model MEM (.pclk, .presetn, .mem_req, .mem_addr, .mem_ack, .mem_err, .mem_rdata);
  always @(posedge pclk) begin
    if (disp_valid === 1'b1) seen_q.push_back({disp_tag, disp_addr, disp_data});
    if (err_valid === 1'b1) errs++;
    if (mem_req === 1'b1 && mem_ack === 1'b1 && mem_err === 1'b0)
      req_q.push_back({mem_wdata, mem_we, mem_space, mem_len});
  end
  task automatic check(input string n, input logic [63:0] s, input logic [63:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic xf(input logic w, input logic [7:0] ad, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge pclk) penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata; slv = pslverr; psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task automatic arg(input logic [31:0] dg, input logic [15:0] pre, input logic [3:0] n);
    xf(1, 8'h14, dg);
    xf(1, 8'h18, {12'h0, n, pre});
  endtask
  task automatic run(input logic [31:0] c);
    xf(1, 8'h00, c);
    q = 32'h1;
    for (int i = 0; i < 100 && q[0] !== 1'b0; i++) xf(0, 8'h08, 0);
    check("cmd_done", q[0], 1'b0);
  endtask
  task automatic acc(input logic [31:0] ad, input logic g, input int l);
    logic [103:0] v;
    logic [69:0] r;
    logic [63:0] m;
    m = (l == 3) ? '1 : (64'h1 << (8 << l)) - 64'h1;
    v = seen_q.size() ? seen_q.pop_front() : 'x;
    r = req_q.size() ? req_q.pop_front() : 'x;
    check("disp_tag", v[103:96], g ? 8'h47 : 8'h50);
    check("disp_addr", v[95:64], ad);
    check("disp_data", v[63:0], dep ? {32'h0, a} & m : {~ad, ad} & m);
    check("mem_len", r[1:0], l);
    check("mem_space", r[4:2], sp);
    check("mem_we", r[5], dep);
    if (dep) check("mem_wdata", r[69:6], {32'h0, a} & m);
    def_a = (sp == 3'h4) ? (ad + 1) % 16 : g ? ad + 1 : ad + (1 << l);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #2000000;
    fails++;
    give_verdict;
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    xf(0, 8'h04, 0); check("defaults", q, 32'h11);
    xf(0, 8'h0c, 0); check("def_addr", q, 0);
    $display("test reset done");
    for (int l = 0; l < 4; l++) begin
      a = $random(seed) & 32'h7ffffff0;
      arg(a, 0, 8); run(32'h20 | (l << 6)); acc(a, 0, l);
      xf(0, 8'h0c, 0); check("def_addr", q, def_a);
      run(32'h100); acc(def_a, 0, 2);
      run(32'h1200); acc(def_a, 0, 2); acc(def_a, 0, 2);
    end
    $display("test lengths done");
    arg(32'h7654, 16'h254f, 4); run(0); acc(32'hfac, 0, 2);
    arg(32'h7654, 16'h2578, 4); run(0); acc(32'h7654, 0, 2);
    xf(1, 8'h04, 32'h31); arg(32'h7654, 0, 4); run(0); acc(32'hfac, 0, 2);
    xf(1, 8'h04, 32'h09); run(32'h100); acc(def_a, 0, 1);
    xf(1, 8'h04, 32'h08); sp = 0; arg(32'h100, 0, 3); run(0); acc(32'h100, 0, 1);
    dep = 1; xf(1, 8'h1c, a); xf(1, 8'h20, 32'h80000); run(32'h261); acc(def_a, 0, 1); dep = 0;
    xf(0, 8'h0c, 0); check("def_addr", q, def_a);
    $display("test radix done");
    for (int s = 0; s < 6; s++) begin
      sp = s;
      arg(32'h40, 0, 2); run(32'h22 | (s << 2)); acc(32'h40, s >= 4, s >= 4 ? 2 : 0);
    end
    sp = 4;
    run(32'h00021400); acc(32'hf, 1, 2); acc(0, 1, 2); acc(1, 1, 2);
    run(32'h320); acc(1, 1, 2);
    xf(0, 8'h10, 0); check("last_addr", q, 1);
    $display("test registers done");
    arg(32'h7654, 0, 4); xf(1, 8'h00, 32'h00ff1000); run(32'h80000000);
    check("abort_stops", seen_q.size() > 0 && seen_q.size() < 20, 1);
    seen_q.delete();
    req_q.delete();
    arg(32'hdead, 0, 4); run(0); check("err_pulse", errs, 1);
    xf(0, 8'h08, 0); check("err_flag", q[1], 1);
    check("err_no_disp", seen_q.size(), 0);
    xf(0, 8'h3c, 0); check("unmapped", slv, 1);
    $display("test errors done");
    give_verdict;
  end
endmodule
`default_nettype wire
